// ### rtl/pwcr_regs.sv
// power-down config set/clear ports and wake enable register over axi4-lite
`timescale 1ns/10ps
`default_nettype none
module pwcr_regs
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // axi4-lite write
    input wire logic [31:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    // axi4-lite read
    input wire logic [31:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    // system state
    input wire logic [1:0] power_mode_i,
    input wire logic cpu_running_i,
    input wire logic [31:0] clk_kept_i,
    // pin-interrupt pattern match requests
    input wire logic pattern_match_irq_i,
    // wake sources
    input wire logic [31:0] wake_src_irq_i,
    // outputs
    output logic [31:0] power_down_config_o,
    output logic [31:0] wake_enable_bank0_o,
    output logic wake_request_o
);
    // ------------------------------------------------
    // write channel state
    // ------------------------------------------------
    logic aw_held_q, aw_held_d;
    logic w_held_q, w_held_d;
    logic [31:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic [31:0] pd_q, pd_d;
    logic [31:0] wake_q, wake_d;
    logic do_write;
    pwcr_pkg::pwcr_wreq_t req;

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    always_comb
    begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        pd_d = pd_q;
        wake_d = wake_q;
        if (s_awvalid_i && s_awready_o)
        begin
            aw_held_d = 1'b1;
            awaddr_d = s_awaddr_i;
        end
        if (s_wvalid_i && s_wready_o)
        begin
            w_held_d = 1'b1;
            wdata_d = s_wdata_i;
            wstrb_d = s_wstrb_i;
        end
        req.addr = awaddr_q;
        req.data = wdata_q;
        req.strb = wstrb_q;
        do_write = aw_held_q && w_held_q && !bvalid_q;
        if (do_write)
        begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = pwcr_pkg::PWCR_RESP_OKAY;
            case (req.addr)
                pwcr_pkg::PWCR_PD_CFG_ADDR:
                begin
                    pd_d = merge(pd_q, req.data, strb_mask(req.strb) & pwcr_pkg::PWCR_PD_IMPL);
                end
                pwcr_pkg::PWCR_POWER_BITS_TO_SET_ADDR:
                begin
                    pd_d = pd_q | (req.data & strb_mask(req.strb) & pwcr_pkg::PWCR_PD_IMPL);
                end
                pwcr_pkg::PWCR_POWER_BITS_TO_CLEAR_ADDR:
                begin
                    pd_d = pd_q & ~(req.data & strb_mask(req.strb) & pwcr_pkg::PWCR_PD_IMPL);
                end
                pwcr_pkg::PWCR_WAKE0_ADDR:
                begin
                    wake_d = merge(wake_q, req.data, strb_mask(req.strb) & pwcr_pkg::PWCR_WAKE_IMPL);
                end
                default:
                begin
                    bresp_d = pwcr_pkg::PWCR_RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_q && s_bready_i)
        begin
            bvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 32'h00000000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            pd_q <= pwcr_pkg::PWCR_PD_RESET;
            wake_q <= pwcr_pkg::PWCR_WAKE_RESET;
        end
        else
        begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            pd_q <= pd_d;
            wake_q <= wake_d;
        end
    end

    assign s_awready_o = !aw_held_q && !bvalid_q;
    assign s_wready_o = !w_held_q && !bvalid_q;
    assign s_bvalid_o = bvalid_q;
    assign s_bresp_o = bresp_q;

    // ------------------------------------------------
    // read channel
    // ------------------------------------------------
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_arvalid_i && s_arready_o)
        begin
            rvalid_d = 1'b1;
            rresp_d = pwcr_pkg::PWCR_RESP_OKAY;
            case (s_araddr_i)
                pwcr_pkg::PWCR_PD_CFG_ADDR:
                begin
                    rdata_d = pd_q;
                end
                pwcr_pkg::PWCR_POWER_BITS_TO_SET_ADDR,
                pwcr_pkg::PWCR_POWER_BITS_TO_CLEAR_ADDR:
                begin
                    rdata_d = 32'h00000000;
                end
                pwcr_pkg::PWCR_WAKE0_ADDR:
                begin
                    rdata_d = wake_q & pwcr_pkg::PWCR_WAKE_IMPL;
                end
                pwcr_pkg::PWCR_MODE_ADDR:
                begin
                    rdata_d = {29'h00000000, wake_request_o, power_mode_i};
                end
                default:
                begin
                    rdata_d = 32'h00000000;
                    rresp_d = pwcr_pkg::PWCR_RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_q && s_rready_i)
        begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'h0;
        end
        else
        begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_arready_o = !rvalid_q;
    assign s_rvalid_o = rvalid_q;
    assign s_rdata_o = rdata_q;
    assign s_rresp_o = rresp_q;

    // ------------------------------------------------
    // wake logic
    // ------------------------------------------------
    logic wake_comb;
    logic wake_q2, wake_d2;
    logic unused_pm;

    // pattern match is never routed into the gate
    assign unused_pm = pattern_match_irq_i;

    pwcr_wake_gate u_gate
    (
        .enable_i(wake_q),
        .clk_kept_i(clk_kept_i),
        .mode_i(power_mode_i),
        .cpu_running_i(cpu_running_i),
        .irq_i(wake_src_irq_i),
        .wake_o(wake_comb)
    );

    always_comb
    begin
        wake_d2 = wake_comb & ~unused_pm | wake_comb;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wake_q2 <= 1'b0;
        end
        else
        begin
            wake_q2 <= wake_d2;
        end
    end

    assign wake_request_o = wake_q2;
    assign power_down_config_o = pd_q;
    assign wake_enable_bank0_o = wake_q;
endmodule
`default_nettype wire

// ### rtl/pwcr_pkg.sv
// constants and types for the power and wake configuration registers
// Summary of operation
// - each one written to the set port sets that power-down config bit
// - each one written to the clear port clears that power-down config bit
// - set and clear ports are write-only and hold no reset value
// - set/clear writes touch only implemented power-down config bits
// - a wake enable bit of one lets its source wake from deep modes
// - all defined wake enable bits are zero after reset
// - bits 0,1,3,4: watchdog, brown-out, DMA, group pin interrupt 0
// - bits 5..8: pin interrupts 0..3, edge or level, never pattern match
// - bit 9 micro-tick, 10 multi-rate, 11..15 counter timers, 16 state timer
// - bits 17..20 serial ports, 21..23 two-wire, 24..25 sync serial
// - bits 26..28 converter, 29 real-time clock, 31 mailbox
// - bits 2 and 30 reserved; read zero here, software writes zero
// - pattern match never wakes from modes deeper than sleep
// - mailbox wake only while at least one processor runs
// - sources with stopped clocks wake only if their clock is kept running
// - power-down config bit zero keeps block powered, one powers it down
package pwcr_pkg;
    localparam logic [31:0] PWCR_PD_CFG_ADDR = 32'h40000210;
    localparam logic [31:0] PWCR_POWER_BITS_TO_SET_ADDR = 32'h40000214;
    localparam logic [31:0] PWCR_POWER_BITS_TO_CLEAR_ADDR = 32'h40000218;
    localparam logic [31:0] PWCR_WAKE0_ADDR = 32'h40000240;
    localparam logic [31:0] PWCR_MODE_ADDR = 32'h40000260;
    // implemented power-down config bits and their reset value
    localparam logic [31:0] PWCR_PD_IMPL = 32'h01DBE5B8;
    localparam logic [31:0] PWCR_PD_RESET = 32'h00D80500;
    // defined wake enable bits (2 and 30 reserved)
    localparam logic [31:0] PWCR_WAKE_IMPL = 32'hBFFFFFFB;
    localparam logic [31:0] PWCR_WAKE_RESET = 32'h00000000;
    // sources whose clock stops in deep modes
    localparam logic [31:0] PWCR_CLK_DEP = 32'h1C01FC08;
    localparam int PWCR_MBOX_BIT = 31;
    localparam logic [1:0] PWCR_RESP_OKAY = 2'h0;
    localparam logic [1:0] PWCR_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0]
    {
        PWCR_RUN = 2'b00,
        PWCR_SLEEP = 2'b01,
        PWCR_DEEP_SLEEP = 2'b10,
        PWCR_POWER_DOWN = 2'b11
    } pwcr_mode_t;
    typedef struct packed
    {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } pwcr_wreq_t;
endpackage

// ### rtl/pwcr_wake_gate.sv
// wake request gating per source
`timescale 1ns/10ps
`default_nettype none
module pwcr_wake_gate
(
    // control
    input wire logic [31:0] enable_i,
    input wire logic [31:0] clk_kept_i,
    input wire logic [1:0] mode_i,
    input wire logic cpu_running_i,
    // sources
    input wire logic [31:0] irq_i,
    // result
    output logic wake_o
);
    logic [31:0] eligible;
    logic deep;
    always_comb
    begin
        deep = (mode_i == pwcr_pkg::PWCR_DEEP_SLEEP) || (mode_i == pwcr_pkg::PWCR_POWER_DOWN);
        // stopped-clock sources drop out unless their clock is kept
        eligible = irq_i & enable_i & pwcr_pkg::PWCR_WAKE_IMPL & (~pwcr_pkg::PWCR_CLK_DEP | clk_kept_i);
        eligible[pwcr_pkg::PWCR_MBOX_BIT] = eligible[pwcr_pkg::PWCR_MBOX_BIT] & cpu_running_i;
        wake_o = deep && (|eligible);
    end
endmodule
`default_nettype wire

// ### testbench/pwcr_regs_properties.sv
// concurrent checks on the power and wake register ports
`timescale 1ns/10ps
`default_nettype none
module pwcr_regs_properties
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // write channels
    input wire logic [31:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    input wire logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    input wire logic s_wready_o,
    input wire logic [1:0] s_bresp_o,
    input wire logic s_bvalid_o,
    // system state and sources
    input wire logic [1:0] power_mode_i,
    input wire logic cpu_running_i,
    input wire logic [31:0] clk_kept_i,
    input wire logic [31:0] wake_src_irq_i,
    // outputs
    input wire logic [31:0] power_down_config_o,
    input wire logic [31:0] wake_enable_bank0_o,
    input wire logic wake_request_o
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire aw_t = s_awvalid_i && s_awready_o;
    wire w_t = s_wvalid_i && s_wready_o;
    wire full_w = aw_t && w_t && (s_wstrb_i == 4'hF);
    wire cause = power_mode_i[1] && (|(wake_enable_bank0_o & wake_src_irq_i
        & (~pwcr_pkg::PWCR_CLK_DEP | clk_kept_i) & {cpu_running_i, 31'h7FFFFFFF}));
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_WAKE_ON: assert property (cause |=> wake_request_o)
        else $error("wake request missing");
    AST_WAKE_OFF: assert property (!cause |=> !wake_request_o)
        else $error("wake request without cause");
    AST_SET: assert property (full_w && s_awaddr_i == pwcr_pkg::PWCR_POWER_BITS_TO_SET_ADDR |-> ##2
        power_down_config_o == ($past(power_down_config_o, 2) | ($past(s_wdata_i, 2) & pwcr_pkg::PWCR_PD_IMPL)))
        else $error("set port result wrong");
    AST_CLR: assert property (full_w && s_awaddr_i == pwcr_pkg::PWCR_POWER_BITS_TO_CLEAR_ADDR |-> ##2
        power_down_config_o == ($past(power_down_config_o, 2) & ~($past(s_wdata_i, 2) & pwcr_pkg::PWCR_PD_IMPL)))
        else $error("clear port result wrong");
    AST_CFG_IMPL: assert property ((power_down_config_o & ~pwcr_pkg::PWCR_PD_IMPL) == 32'h0)
        else $error("unimplemented config bit set");
    AST_WAKE_RSVD: assert property ((wake_enable_bank0_o & ~pwcr_pkg::PWCR_WAKE_IMPL) == 32'h0)
        else $error("reserved wake bit set");
    AST_QUIET: assert property (!s_bvalid_o |-> $stable(power_down_config_o) && $stable(wake_enable_bank0_o))
        else $error("register changed without write");
    AST_B_ANS: assert property (aw_t && w_t |-> ##2 s_bvalid_o)
        else $error("write response late");
    // ----------------------------------------
    // coverage
    // ----------------------------------------
    cover property (cause);
    cover property (full_w && s_awaddr_i == pwcr_pkg::PWCR_POWER_BITS_TO_CLEAR_ADDR);
    cover property (s_bvalid_o && s_bresp_o == pwcr_pkg::PWCR_RESP_SLVERR);
endmodule
`default_nettype wire

// ### testbench/pwcr_regs_tb.sv
// self-checking bench for the power and wake registers
`timescale 1ns/10ps
`default_nettype none
module pwcr_regs_tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk_i, rst_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i, cpu_running_i, pattern_match_irq_i;
    logic [31:0] s_awaddr_i, s_wdata_i, s_araddr_i, clk_kept_i, wake_src_irq_i, s_rdata_o, rd_data;
    logic [31:0] power_down_config_o, wake_enable_bank0_o;
    logic [3:0] s_wstrb_i;
    logic [1:0] power_mode_i, s_bresp_o, s_rresp_o, rsp;
    logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, wake_request_o;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    typedef struct packed {logic [31:0] wa; logic [31:0] wd; logic [31:0] ra; logic [31:0] re;} pwcr_row_t;
    pwcr_row_t rows [7] = '{
        '{pwcr_pkg::PWCR_POWER_BITS_TO_SET_ADDR, 32'hFFFFFFFF, pwcr_pkg::PWCR_PD_CFG_ADDR, 32'h01DBE5B8},
        '{pwcr_pkg::PWCR_POWER_BITS_TO_CLEAR_ADDR, 32'h00000500, pwcr_pkg::PWCR_PD_CFG_ADDR, 32'h01DBE0B8},
        '{pwcr_pkg::PWCR_POWER_BITS_TO_CLEAR_ADDR, 32'hFFFFFFFF, pwcr_pkg::PWCR_PD_CFG_ADDR, 32'h00000000},
        '{pwcr_pkg::PWCR_POWER_BITS_TO_SET_ADDR, 32'h00000018, pwcr_pkg::PWCR_PD_CFG_ADDR, 32'h00000018},
        '{pwcr_pkg::PWCR_POWER_BITS_TO_CLEAR_ADDR, 32'h00000000, pwcr_pkg::PWCR_POWER_BITS_TO_CLEAR_ADDR, 32'h00000000},
        '{pwcr_pkg::PWCR_WAKE0_ADDR, 32'h40000004, pwcr_pkg::PWCR_WAKE0_ADDR, 32'h00000000},
        '{pwcr_pkg::PWCR_WAKE0_ADDR, 32'hFFFFFFFF, pwcr_pkg::PWCR_WAKE0_ADDR, 32'hBFFFFFFB}};
    pwcr_regs dut (.clk_i, .rst_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i, .s_wstrb_i, .s_wvalid_i,
        .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i, .s_arready_o, .s_rdata_o,
        .s_rresp_o, .s_rvalid_o, .s_rready_i, .power_mode_i, .cpu_running_i, .clk_kept_i, .pattern_match_irq_i,
        .wake_src_irq_i, .power_down_config_o, .wake_enable_bank0_o, .wake_request_o);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw = 1'b1;
        logic w = 1'b1;
        logic done = 1'b0;
        logic aw_ok;
        logic w_ok;
        @(posedge clk_i);
        s_awaddr_i <= a;
        s_wdata_i <= d;
        s_awvalid_i <= 1'b1;
        s_wvalid_i <= 1'b1;
        s_bready_i <= 1'b1;
        while (!done)
        begin
            @(negedge clk_i);
            aw_ok = aw && s_awready_o;
            w_ok = w && s_wready_o;
            done = s_bvalid_o;
            if (done)
                rsp = s_bresp_o;
            @(posedge clk_i);
            if (aw_ok)
            begin
                aw = 1'b0;
                s_awvalid_i <= 1'b0;
            end
            if (w_ok)
            begin
                w = 1'b0;
                s_wvalid_i <= 1'b0;
            end
            if (done)
                s_bready_i <= 1'b0;
        end
    endtask
    task automatic rd(input logic [31:0] a);
        logic done = 1'b0;
        logic ar_ok;
        @(posedge clk_i);
        s_araddr_i <= a;
        s_arvalid_i <= 1'b1;
        s_rready_i <= 1'b1;
        while (!done)
        begin
            @(negedge clk_i);
            ar_ok = s_arvalid_i && s_arready_o;
            done = s_rvalid_o;
            if (done)
            begin
                rd_data = s_rdata_o;
                rsp = s_rresp_o;
            end
            @(posedge clk_i);
            if (ar_ok)
                s_arvalid_i <= 1'b0;
            if (done)
                s_rready_i <= 1'b0;
        end
    endtask
    task automatic wk(input logic [1:0] m, input logic k, input logic c, input logic [31:0] s, input logic e);
        @(posedge clk_i);
        power_mode_i <= m;
        clk_kept_i <= {32{k}};
        cpu_running_i <= c;
        wake_src_irq_i <= s;
        repeat (2) @(posedge clk_i);
        #1;
        chk({31'h0, wake_request_o}, {31'h0, e});
    endtask
    task automatic rst_chk;
        rd(pwcr_pkg::PWCR_PD_CFG_ADDR);
        chk(rd_data, pwcr_pkg::PWCR_PD_RESET);
        chk(power_down_config_o, pwcr_pkg::PWCR_PD_RESET);
        rd(pwcr_pkg::PWCR_WAKE0_ADDR);
        chk(rd_data, 32'h0);
        chk(wake_enable_bank0_o, pwcr_pkg::PWCR_WAKE_RESET);
    endtask
    task automatic close_out;
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ----------------------------------------
    // clock, timeout and sequence
    // ----------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares++;
            close_out;
        end
    end
    initial
    begin
        {rst_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i} = 6'h20;
        {cpu_running_i, pattern_match_irq_i, power_mode_i} = 4'h0;
        {s_awaddr_i, s_wdata_i, s_araddr_i, clk_kept_i, wake_src_irq_i} = '0;
        s_wstrb_i = 4'hF;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rst_chk();
        foreach (rows[i])
        begin
            wr(rows[i].wa, rows[i].wd);
            chk({30'h0, rsp}, {30'h0, pwcr_pkg::PWCR_RESP_OKAY});
            rd(rows[i].ra);
            chk(rd_data, rows[i].re);
        end
        for (int b = 0; b < 32; b++)
            if (b != 2 && b != 30)
                wk(2'h2 + 2'(b % 2), 1'b1, 1'b1, 32'h1 << b, 1'b1);
        wk(2'h1, 1'b1, 1'b1, 32'hFFFFFFFF, 1'b0);
        wk(2'h3, 1'b0, 1'b1, 32'h1C01FC08, 1'b0);
        wk(2'h3, 1'b0, 1'b1, 32'h00000200, 1'b1);
        rd(pwcr_pkg::PWCR_MODE_ADDR);
        chk(rd_data, 32'h00000007);
        wk(2'h2, 1'b1, 1'b0, 32'h80000000, 1'b0);
        @(posedge clk_i);
        pattern_match_irq_i <= 1'b1;
        wk(2'h2, 1'b1, 1'b1, 32'h0, 1'b0);
        wr(32'h40000300, 32'hFFFFFFFF);
        chk({30'h0, rsp}, {30'h0, pwcr_pkg::PWCR_RESP_SLVERR});
        rd(32'h40000300);
        chk({rd_data[29:0], rsp}, {30'h0, pwcr_pkg::PWCR_RESP_SLVERR});
        wr(pwcr_pkg::PWCR_WAKE0_ADDR, 32'h0);
        wk(2'h3, 1'b1, 1'b1, 32'hFFFFFFFF, 1'b0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rst_chk();
        wr(pwcr_pkg::PWCR_POWER_BITS_TO_SET_ADDR, pwcr_pkg::PWCR_PD_IMPL);
        rd(pwcr_pkg::PWCR_PD_CFG_ADDR);
        chk(rd_data, pwcr_pkg::PWCR_PD_IMPL);
        close_out;
    end
endmodule
bind pwcr_regs pwcr_regs_properties u_props (.clk_i, .rst_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i,
    .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .power_mode_i, .cpu_running_i, .clk_kept_i,
    .wake_src_irq_i, .power_down_config_o, .wake_enable_bank0_o, .wake_request_o);
`default_nettype wire
